// ===== core/dlp_map.svh
// register offsets, field positions and reset values of the line protect block
`ifndef DLP_MAP_SVH
`define DLP_MAP_SVH
`define DLP_IDX_PROTECT 8'h11
`define DLP_IDX_COUNTRY 8'h12
`define DLP_IDX_LINK 8'h13
`define DLP_ADDR_PROTECT 12'h044
`define DLP_ADDR_COUNTRY 12'h048
`define DLP_ADDR_LINK 12'h04c
`define DLP_BIT_CAL_TRIG 6
`define DLP_BIT_CAL_OFF 5
`define DLP_BIT_CAP_EN 4
`define DLP_BIT_OVL_EN 3
`define DLP_BIT_TONE_EN 2
`define DLP_BIT_RX_OVL 1
`define DLP_BIT_TONE_DET 0
`define DLP_LINK_OFFHOOK 0
`define DLP_LINK_MODE_LO 1
`define DLP_LINK_OVL_FLAG 3
`define DLP_RST_PROTECT 8'h00
`define DLP_RST_COUNTRY 8'h00
`define DLP_RST_LINK 8'h00
`define DLP_LOOP_OVERLOAD 4'hf
`define DLP_MODE_CTR21 2'h3
`endif

// ===== core/dlp_pkg.sv
// types shared by the line protect block
package dlp_pkg;
  typedef enum logic [1:0] {
    DLP_TERM_NORMAL,
    DLP_TERM_OVERLOAD,
    DLP_TERM_BILLING
  } dlp_term_t;
endpackage : dlp_pkg

// ===== core/dlp_line_protect.sv
// line protect and calibration control register bank with apb slave
// Overview of operation
// - writing one starts a calibration cycle
// - disable bit skips automatic calibration
// - current cap only in ctr21 mode
// - loop overload off-hook cuts termination, flags
// - billing tone rise cuts termination, stops tracking
// - otherwise termination pin tracks receive input
// - receive overload sticky, cleared by writing zero
// - country register eight rw fields reset zero
`timescale 1ns/1ns
`include "dlp_map.svh"
module dlp_line_protect
  import dlp_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [3:0] LOOP_SENSE_READING,
  input wire logic BILLING_TONE_DETECTED,
  input wire logic RX_BELOW_GROUND,
  output logic CAL_START,
  output logic AUTO_CAL_EN,
  output logic CURRENT_CAP_ACTIVE,
  output logic TERM_800_OHM,
  output logic HOOK_CURRENT_REDUCE,
  output logic TERM_TRACK_RX
);
  logic [7:0] protect;
  logic [7:0] country;
  logic [7:0] link;
  logic ovl_flag;
  logic cal_pulse;
  logic [3:0] loop_s1, loop_s2;
  logic tone_s1, tone_s2, tone_d;
  logic rxo_s1, rxo_s2;
  dlp_term_t term, next_term;

  // apb decode; access completes in one cycle
  wire access = PSEL && PENABLE;
  wire wr = access && PWRITE;
  wire hit_prot = PADDR == `DLP_ADDR_PROTECT;
  wire hit_ctry = PADDR == `DLP_ADDR_COUNTRY;
  wire hit_link = PADDR == `DLP_ADDR_LINK;
  wire mapped = hit_prot || hit_ctry || hit_link;
  wire wr_prot = wr && hit_prot;
  wire wr_ctry = wr && hit_ctry;
  wire wr_link = wr && hit_link;
  assign PREADY = 1'b1;
  assign PSLVERR = access && !mapped;

  // protection conditions
  wire off_hook = link[`DLP_LINK_OFFHOOK];
  wire [1:0] term_mode = link[`DLP_LINK_MODE_LO+1:`DLP_LINK_MODE_LO];
  wire ovl_en = protect[`DLP_BIT_OVL_EN];
  wire tone_en = protect[`DLP_BIT_TONE_EN];
  wire loop_over = loop_s2 == `DLP_LOOP_OVERLOAD;
  wire tone_rise = tone_s2 && !tone_d;
  wire rxo_set = rxo_s2;

  // read view: detector bit and overload flag are live state
  wire [7:0] prot_view = {1'b0, protect[6:2], protect[`DLP_BIT_RX_OVL],
                          tone_s2};
  wire [7:0] link_view = {4'h0, ovl_flag, link[2:0]};
  wire [7:0] rd_mux = hit_prot ? prot_view :
                      hit_ctry ? country :
                      hit_link ? link_view : 8'h00;

  // pin synchronisers
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      loop_s1 <= 4'h0;
      loop_s2 <= 4'h0;
      tone_s1 <= 1'b0;
      tone_s2 <= 1'b0;
      tone_d <= 1'b0;
      rxo_s1 <= 1'b0;
      rxo_s2 <= 1'b0;
    end else begin
      loop_s1 <= LOOP_SENSE_READING;
      loop_s2 <= loop_s1;
      tone_s1 <= BILLING_TONE_DETECTED;
      tone_s2 <= tone_s1;
      tone_d <= tone_s2;
      rxo_s1 <= RX_BELOW_GROUND;
      rxo_s2 <= rxo_s1;
    end
  end

  // protect register; bit 7 stays zero, overload set beats software clear
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      protect <= `DLP_RST_PROTECT;
    end else begin
      if (wr_prot) begin
        protect[6:2] <= PWDATA[6:2];
      end
      if (rxo_set) begin
        protect[`DLP_BIT_RX_OVL] <= 1'b1;
      end else if (wr_prot && !PWDATA[`DLP_BIT_RX_OVL]) begin
        protect[`DLP_BIT_RX_OVL] <= 1'b0;
      end
    end
  end

  // country register, plain storage
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      country <= `DLP_RST_COUNTRY;
    end else if (wr_ctry) begin
      country <= PWDATA[7:0];
    end
  end

  // link register: hook state and termination mode
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      link <= `DLP_RST_LINK;
    end else if (wr_link) begin
      link <= {5'h00, PWDATA[2:0]};
    end
  end

  // calibration start pulse on a write of one
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cal_pulse <= 1'b0;
    end else begin
      cal_pulse <= wr_prot && PWDATA[`DLP_BIT_CAL_TRIG];
    end
  end

  // termination state machine
  always_comb begin
    next_term = term;
    case (term)
      DLP_TERM_NORMAL: begin
        if (off_hook && ovl_en && loop_over) begin
          next_term = DLP_TERM_OVERLOAD;
        end else if (off_hook && tone_en && tone_rise) begin
          next_term = DLP_TERM_BILLING;
        end
      end
      DLP_TERM_OVERLOAD: begin
        if (!ovl_en || !off_hook) begin
          next_term = DLP_TERM_NORMAL;
        end
      end
      DLP_TERM_BILLING: begin
        if (!tone_en || !off_hook) begin
          next_term = DLP_TERM_NORMAL;
        end
      end
      default: next_term = DLP_TERM_NORMAL;
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      term <= DLP_TERM_NORMAL;
    end else begin
      term <= next_term;
    end
  end

  // overload detected flag, cleared when overload protection is disabled
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ovl_flag <= 1'b0;
    end else if (next_term == DLP_TERM_OVERLOAD) begin
      ovl_flag <= 1'b1;
    end else if (!ovl_en) begin
      ovl_flag <= 1'b0;
    end
  end

  // registered outputs
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      PRDATA <= 32'h0000_0000;
      AUTO_CAL_EN <= 1'b1;
      CURRENT_CAP_ACTIVE <= 1'b0;
      TERM_800_OHM <= 1'b0;
      HOOK_CURRENT_REDUCE <= 1'b0;
      TERM_TRACK_RX <= 1'b1;
    end else begin
      if (PSEL && !PENABLE && !PWRITE) begin
        PRDATA <= {24'h00_0000, rd_mux};
      end
      AUTO_CAL_EN <= !protect[`DLP_BIT_CAL_OFF];
      CURRENT_CAP_ACTIVE <= protect[`DLP_BIT_CAP_EN] &&
        (term_mode == `DLP_MODE_CTR21);
      TERM_800_OHM <= next_term != DLP_TERM_NORMAL;
      HOOK_CURRENT_REDUCE <= next_term == DLP_TERM_OVERLOAD;
      TERM_TRACK_RX <= next_term != DLP_TERM_BILLING;
    end
  end
  assign CAL_START = cal_pulse;

  a_cal_start: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    (wr_prot && PWDATA[`DLP_BIT_CAL_TRIG]) |=> CAL_START)
    else $error("calibration not started");
  a_auto_cal: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    $past(protect[`DLP_BIT_CAL_OFF]) |-> !AUTO_CAL_EN)
    else $error("auto calibration not skipped");
  a_cap_mode: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    CURRENT_CAP_ACTIVE |-> $past(term_mode) == `DLP_MODE_CTR21)
    else $error("current cap outside ctr21");
  a_overload_cut: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    (term == DLP_TERM_NORMAL && off_hook && ovl_en && loop_over)
    |=> TERM_800_OHM && HOOK_CURRENT_REDUCE && ovl_flag)
    else $error("overload not handled");
  a_billing_cut: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    (term == DLP_TERM_NORMAL && off_hook && tone_en && tone_rise &&
     !loop_over) |=> TERM_800_OHM && !TERM_TRACK_RX)
    else $error("billing tone not handled");
  a_term_track: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    (term != DLP_TERM_BILLING) |-> TERM_TRACK_RX)
    else $error("termination pin not tracking");
  a_rxo_sticky: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    (protect[`DLP_BIT_RX_OVL] && !wr_prot) |=> protect[`DLP_BIT_RX_OVL])
    else $error("receive overload lost");
  a_rxo_set: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    rxo_s2 |=> protect[`DLP_BIT_RX_OVL])
    else $error("receive overload not set");
  a_country_wr: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    wr_ctry |=> country == $past(PWDATA[7:0]))
    else $error("country register not written");
endmodule : dlp_line_protect

// ===== tb/dlp_line_model.sv
// line side model feeding the protect block sense pins
`timescale 1ns/1ns
module dlp_line_model (
  input wire logic overload,
  input wire logic tone,
  input wire logic rx_low,
  output logic [3:0] loop_sense,
  output logic tone_det,
  output logic rx_below
);
  // loop current at full scale only while the line is overloaded
  assign loop_sense = overload ? 4'hf : 4'h5;
  assign tone_det = tone;
  assign rx_below = rx_low;
endmodule : dlp_line_model

// ===== tb/dlp_line_protect_tb_top.sv
// bench for the line protect register bank
`timescale 1ns/1ns
`include "dlp_map.svh"
module dlp_line_protect_tb_top;
  logic CLK = 0;
  logic SYS_RST = 1;
  logic psel = 0, penable = 0, pwrite = 0, ovl = 0, tone = 0, rxl = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rdata, prdata;
  logic pready, pslverr, slverr, tone_det, rx_below;
  logic cal, auto_cal, cap, term, hook, track;
  logic [3:0] loop_sense;
  int fails = 0, checks = 0;
  always #20 CLK = ~CLK;
  dlp_line_model dlp_line_model_inst (.overload(ovl), .tone(tone),
    .rx_low(rxl), .loop_sense(loop_sense), .tone_det(tone_det),
    .rx_below(rx_below));
  dlp_line_protect dlp_line_protect_inst (.CLK(CLK), .SYS_RST(SYS_RST),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .LOOP_SENSE_READING(loop_sense), .BILLING_TONE_DETECTED(tone_det),
    .RX_BELOW_GROUND(rx_below), .CAL_START(cal), .AUTO_CAL_EN(auto_cal),
    .CURRENT_CAP_ACTIVE(cap), .TERM_800_OHM(term),
    .HOOK_CURRENT_REDUCE(hook), .TERM_TRACK_RX(track));
  task end_sim;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge CLK);
    penable <= 1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      fails++;
      end_sim();
    end
    rdata = prdata;
    slverr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr
  task rd(input string nm, input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, {24'h0, e}, rdata);
  endtask : rd
  task pins(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : pins
  // counts calibration pulses over a few cycles after a write
  task pulses(input int e);
    int c;
    c = 0;
    repeat (4) begin
      #1;
      c += (cal === 1'b1);
      @(posedge CLK);
    end
    chk("cal pulses", e, c);
  endtask : pulses
  task t_reset;
    rd("protect", `DLP_ADDR_PROTECT, 8'h00);
    rd("country", `DLP_ADDR_COUNTRY, 8'h00);
    chk("auto cal", 1, auto_cal);
    chk("track", 1, track);
  endtask : t_reset
  task t_cal;
    wr(`DLP_ADDR_PROTECT, 8'h40);
    pulses(1);
    wr(`DLP_ADDR_PROTECT, 8'h20);
    pulses(0);
    chk("auto cal", 0, auto_cal);
    wr(`DLP_ADDR_PROTECT, 8'h00);
  endtask : t_cal
  task t_cap;
    wr(`DLP_ADDR_LINK, 8'h06);
    wr(`DLP_ADDR_PROTECT, 8'h10);
    pins(2);
    chk("cap ctr21", 1, cap);
    wr(`DLP_ADDR_LINK, 8'h04);
    pins(2);
    chk("cap other", 0, cap);
  endtask : t_cap
  task t_ovl;
    wr(`DLP_ADDR_LINK, 8'h01);
    wr(`DLP_ADDR_PROTECT, 8'h08);
    ovl <= 1;
    pins(4);
    chk("term", 1, term);
    chk("hook", 1, hook);
    rd("flag", `DLP_ADDR_LINK, 8'h09);
    wr(`DLP_ADDR_PROTECT, 8'h00);
    ovl <= 0;
    pins(4);
    chk("term off", 0, term);
  endtask : t_ovl
  task t_bill;
    wr(`DLP_ADDR_PROTECT, 8'h04);
    tone <= 1;
    pins(4);
    chk("term", 1, term);
    chk("track", 0, track);
    chk("hook", 0, hook);
    rd("tone", `DLP_ADDR_PROTECT, 8'h05);
    tone <= 0;
    wr(`DLP_ADDR_PROTECT, 8'h00);
    pins(4);
    chk("track", 1, track);
  endtask : t_bill
  task t_rxo;
    @(posedge CLK);
    rxl <= 1;
    repeat (4) @(posedge CLK);
    rxl <= 0;
    pins(4);
    rd("rx ovl", `DLP_ADDR_PROTECT, 8'h02);
    wr(`DLP_ADDR_PROTECT, 8'h02);
    rd("rx ovl", `DLP_ADDR_PROTECT, 8'h02);
    wr(`DLP_ADDR_PROTECT, 8'h00);
    rd("rx ovl", `DLP_ADDR_PROTECT, 8'h00);
  endtask : t_rxo
  task t_regs;
    wr(`DLP_ADDR_COUNTRY, 8'ha5);
    rd("country", `DLP_ADDR_COUNTRY, 8'ha5);
    wr(`DLP_ADDR_COUNTRY, 8'h5a);
    rd("country", `DLP_ADDR_COUNTRY, 8'h5a);
    rd("unmapped", 12'h050, 8'h00);
    chk("slverr", 1, slverr);
  endtask : t_regs
  initial begin
    repeat (4) @(posedge CLK);
    SYS_RST <= 0;
    t_reset();
    t_cal();
    t_cap();
    t_ovl();
    t_bill();
    t_rxo();
    t_regs();
    end_sim();
  end
endmodule : dlp_line_protect_tb_top
